/* design/docvc_pkg.sv */
// constants, carrier types and helpers for the dual oscillator clock and core voltage control
// assumes a 40 MHz system clock and a 16-bit byte address on the register bus
// Summary of operation
// - slow oscillator clocks cpu and peripherals
// - fast oscillator feeds cpu and timer
// - two-bit field sets core supply level
// - zero voltage code blocks fast clock selection
// - bit 3 selects fast clock, reads back
// - select write ignored while fast oscillator enable bit clear
// - bit 2 starts or stops fast oscillator
// - reset clears voltage, enable and select
// - sleep stops fast oscillator, gates slow clock to peripherals
// - instruction cycle spans two cpu clock periods
package docvc_pkg;

  localparam logic [15:0] DOCVC_CTRL_OFF   = 16'hff00;
  localparam logic [15:0] DOCVC_STAT_OFF   = 16'hff04;
  localparam logic [3:0]  DOCVC_CTRL_RST   = 4'h0;
  localparam int          DOCVC_SEL_BIT    = 3;
  localparam int          DOCVC_OSC_BIT    = 2;
  localparam int          DOCVC_VDC_HI     = 1;
  localparam int          DOCVC_VDC_LO     = 0;
  localparam logic [1:0]  DOCVC_VDC_1V1    = 2'h0;
  localparam logic [1:0]  DOCVC_VDC_1V3    = 2'h1;
  localparam logic [1:0]  DOCVC_VDC_1V5    = 2'h2;
  localparam logic [1:0]  DOCVC_VDC_1V7    = 2'h3;
  localparam int          DOCVC_SYNC_LEN   = 3;
  localparam int          DOCVC_CLK_HZ     = 40000000;
  localparam int          DOCVC_SLOW_XT_HZ = 32768;
  localparam int          DOCVC_SLOW_RC_HZ = 60000;
  localparam int          DOCVC_FAST_MAX_HZ = 4200000;
  // status register field positions
  localparam int          DOCVC_ST_EFF     = 0;
  localparam int          DOCVC_ST_RUN     = 1;
  localparam int          DOCVC_ST_MUXF    = 2;
  localparam int          DOCVC_ST_RC      = 3;

  typedef struct packed {
    logic       sel;
    logic       osc_en;
    logic [1:0] core_voltage_select;
  } docvc_ctrl_s;

  typedef enum logic [3:0] {
    DOCVC_MUX_SLOW   = 4'h1,
    DOCVC_MUX_PARK_S = 4'h2,
    DOCVC_MUX_FAST   = 4'h4,
    DOCVC_MUX_PARK_F = 4'h8
  } docvc_mux_e;

  typedef struct packed {
    docvc_mux_e st;
    logic       clk;
  } docvc_mux_s;

  function automatic logic docvc_fast_allowed(input docvc_ctrl_s c);
    docvc_fast_allowed = c.osc_en && (c.core_voltage_select != DOCVC_VDC_1V1);
  endfunction : docvc_fast_allowed

endpackage : docvc_pkg

/* design/docvc_glitchfree_mux.sv */
// glitch-free two-source clock multiplexer working on sampled oscillator levels
// assumes both levels are already synchronised to clk_i
`timescale 1ns/1ps
`default_nettype none
module docvc_glitchfree_mux
  import docvc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic slow_lvl_i,
  input  wire logic fast_lvl_i,
  input  wire logic sel_fast_i,
  output logic      clk_o,
  output logic      fast_active_o
);

  docvc_mux_s r;
  docvc_mux_s next_r;

  // a source is only let go while its level is low, and picked up while low,
  // so the output never carries a shortened high phase
  always_comb begin
    next_r = r;
    case (r.st)
      DOCVC_MUX_SLOW: begin
        if (sel_fast_i && !slow_lvl_i) begin
          next_r.st = DOCVC_MUX_PARK_S;
        end
      end
      DOCVC_MUX_PARK_S: begin
        if (!sel_fast_i) begin
          next_r.st = DOCVC_MUX_PARK_F;
        end else if (!fast_lvl_i) begin
          next_r.st = DOCVC_MUX_FAST;
        end
      end
      DOCVC_MUX_FAST: begin
        if (!sel_fast_i && !fast_lvl_i) begin
          next_r.st = DOCVC_MUX_PARK_F;
        end
      end
      DOCVC_MUX_PARK_F: begin
        if (!slow_lvl_i) begin
          next_r.st = DOCVC_MUX_SLOW;
        end
      end
      default: begin
        next_r.st = DOCVC_MUX_SLOW;
      end
    endcase
    case (next_r.st)
      DOCVC_MUX_SLOW: next_r.clk = slow_lvl_i;
      DOCVC_MUX_FAST: next_r.clk = fast_lvl_i;
      default:        next_r.clk = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r.st  <= DOCVC_MUX_SLOW;
      r.clk <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign clk_o         = r.clk;
  assign fast_active_o = (r.st == DOCVC_MUX_FAST);

  chk_no_runt_rise: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(r.clk) |-> (r.st == DOCVC_MUX_SLOW) || (r.st == DOCVC_MUX_FAST))
    else $error("clock output rose while parked");

endmodule : docvc_glitchfree_mux
`default_nettype wire

/* design/docvc_top.sv */
// clock source and core voltage control with a classic wishbone register slave
// assumes oscillator levels arrive as asynchronous pins and sleep_i comes from clk_i logic
`timescale 1ns/1ps
`default_nettype none
module docvc_top
  import docvc_pkg::*;
#(
  parameter bit SLOW_IS_RC = 1'b0
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [15:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        slow_osc_i,
  input  wire logic        fast_osc_i,
  input  wire logic        sleep_i,
  output logic [1:0]       core_voltage_select_o,
  output logic             fast_osc_enable_o,
  output logic             cpu_clock_select_o,
  output logic             cpu_clk_o,
  output logic             periph_clk_o,
  output logic             timer_clk_o,
  output logic             instr_cycle_en_o
);

  typedef struct packed {
    docvc_ctrl_s                ctrl;
    logic [DOCVC_SYNC_LEN-1:0] slow_s;
    logic [DOCVC_SYNC_LEN-1:0] fast_s;
    logic                      slow_f;
    logic                      fast_f;
    logic                      ack;
    logic [3:0]                dat;
    logic                      cpu_clk_d;
    logic                      instr_half;
    logic                      instr_en;
    logic                      periph_clk;
    logic                      timer_clk;
  } docvc_state_s;

  docvc_state_s r;
  docvc_state_s next_r;

  logic       req;
  logic       hit_ctrl;
  logic       hit_stat;
  logic       wr_ctrl;
  logic       fast_run;
  logic       eff_sel;
  logic       mux_clk;
  logic       mux_fast;
  logic [3:0] status;

  // only word-aligned decode; byte lanes above lane 0 carry no storage
  assign req      = wb_cyc_i && wb_stb_i && !r.ack;
  assign hit_ctrl = (wb_adr_i[15:2] == DOCVC_CTRL_OFF[15:2]);
  assign hit_stat = (wb_adr_i[15:2] == DOCVC_STAT_OFF[15:2]);
  assign wr_ctrl  = req && wb_we_i && hit_ctrl && wb_sel_i[0];

  // sleep halts the fast oscillator whatever the enable bit holds
  assign fast_run = r.ctrl.osc_en && !sleep_i;
  assign eff_sel  = r.ctrl.sel && docvc_fast_allowed(r.ctrl);

  assign status[DOCVC_ST_EFF]  = eff_sel;
  assign status[DOCVC_ST_RUN]  = fast_run;
  assign status[DOCVC_ST_MUXF] = mux_fast;
  assign status[DOCVC_ST_RC]   = SLOW_IS_RC;

  always_comb begin
    next_r = r;

    // three-stage pin sampling; a level is accepted once stages two and three agree
    next_r.slow_s = {r.slow_s[DOCVC_SYNC_LEN-2:0], slow_osc_i};
    next_r.fast_s = {r.fast_s[DOCVC_SYNC_LEN-2:0], fast_osc_i};
    if (r.slow_s[1] == r.slow_s[2]) begin
      next_r.slow_f = r.slow_s[2];
    end
    if (r.fast_s[1] == r.fast_s[2]) begin
      next_r.fast_f = r.fast_s[2];
    end

    // register write: the select bit only latches a one when the stored enable bit and voltage code allow the fast path
    if (wr_ctrl) begin
      next_r.ctrl.core_voltage_select    = wb_dat_i[DOCVC_VDC_HI:DOCVC_VDC_LO];
      next_r.ctrl.osc_en = wb_dat_i[DOCVC_OSC_BIT];
      next_r.ctrl.sel    = wb_dat_i[DOCVC_SEL_BIT]
                           && docvc_fast_allowed(r.ctrl);
    end

    // single-cycle answer; unmapped reads return zero, unmapped writes are dropped
    next_r.ack = req;
    next_r.dat = 4'h0;
    if (req && !wb_we_i) begin
      if (hit_ctrl) begin
        next_r.dat = r.ctrl;
      end else if (hit_stat) begin
        next_r.dat = status;
      end
    end

    // an instruction cycle is every second rising edge of the cpu clock
    next_r.cpu_clk_d = mux_clk;
    next_r.instr_en  = 1'b0;
    if (mux_clk && !r.cpu_clk_d) begin
      next_r.instr_half = !r.instr_half;
      next_r.instr_en   = r.instr_half;
    end

    // slow oscillator keeps running in sleep but is cut from the peripherals
    next_r.periph_clk = r.slow_f && !sleep_i;
    next_r.timer_clk  = r.fast_f && fast_run;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r      <= '0;
      r.ctrl <= DOCVC_CTRL_RST;
    end else begin
      r <= next_r;
    end
  end

  docvc_glitchfree_mux u_mux (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .slow_lvl_i    (r.slow_f),
    .fast_lvl_i    (r.fast_f && fast_run),
    .sel_fast_i    (eff_sel),
    .clk_o         (mux_clk),
    .fast_active_o (mux_fast)
  );

  assign wb_ack_o              = r.ack;
  assign wb_dat_o              = {28'h0, r.dat};
  assign core_voltage_select_o = r.ctrl.core_voltage_select;
  assign fast_osc_enable_o     = fast_run;
  assign cpu_clock_select_o    = eff_sel;
  assign cpu_clk_o             = mux_clk;
  assign periph_clk_o          = r.periph_clk;
  assign timer_clk_o           = r.timer_clk;
  assign instr_cycle_en_o      = r.instr_en;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_ctrl_write;
    wb_cyc_i && wb_stb_i && wb_we_i && hit_ctrl && wb_sel_i[0] && !wb_ack_o;
  endsequence

  sequence s_ctrl_read;
    wb_cyc_i && wb_stb_i && !wb_we_i && hit_ctrl && !wb_ack_o;
  endsequence

  chk_reset_clears_ctrl: assert property (disable iff (1'b0)
    rst_i |=> (core_voltage_select_o == 2'h0) && !r.ctrl.osc_en && !r.ctrl.sel)
    else $error("control not cleared by reset");

  chk_voltage_write: assert property (
    s_ctrl_write |=> core_voltage_select_o == $past(wb_dat_i[1:0]))
    else $error("voltage field did not take written value");

  chk_low_volt_block: assert property (
    (core_voltage_select_o == DOCVC_VDC_1V1) |-> !cpu_clock_select_o)
    else $error("fast clock selected at lowest voltage");

  chk_osc_off_write: assert property (
    s_ctrl_write ##0 !r.ctrl.osc_en |=> !r.ctrl.sel && !cpu_clock_select_o)
    else $error("select accepted with fast oscillator off");

  chk_osc_enable_write: assert property (
    s_ctrl_write ##0 !sleep_i |=> (r.ctrl.osc_en == $past(wb_dat_i[2])))
    else $error("oscillator enable did not take written value");

  chk_select_readback: assert property (
    s_ctrl_read |=> wb_ack_o && (wb_dat_o == {28'h0, $past(r.ctrl)}))
    else $error("control read did not return stored value");

  chk_sleep_stops_fast: assert property (
    sleep_i |-> !fast_osc_enable_o ##1 !periph_clk_o)
    else $error("sleep did not stop fast oscillator or gate slow clock");

  chk_instr_spacing: assert property (
    instr_cycle_en_o |=> !instr_cycle_en_o [*2])
    else $error("instruction cycle pulses too close");

  chk_slow_after_reset: assert property (disable iff (1'b0)
    rst_i |=> !mux_fast && !cpu_clock_select_o)
    else $error("cpu clock not on slow source after reset");

  chk_timer_gated: assert property (
    !$past(fast_run) |-> !timer_clk_o)
    else $error("timer clock runs with fast oscillator stopped");

  chk_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held longer than one cycle");

endmodule : docvc_top
`default_nettype wire

/* verif/docvc_top_tb_top.sv */
// self-checking bench for docvc_top: register sequences over classic wishbone
// assumes docvc_pkg is compiled first; oscillator pins are toggled by this bench
`timescale 1ns/1ps
`default_nettype none
module docvc_top_tb_top;
  import docvc_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we, sleep;
  logic        s_osc = 1'b0;
  logic        f_osc = 1'b0;
  logic [15:0] adr;
  logic [31:0] dat, dat_o, q;
  logic [3:0]  sel;
  logic [1:0]  vsel;
  logic        ack, osc_o, sel_o, cpu_clk, per_clk, tim_clk, ie_o;
  int          error_cnt, n_checks, cr, pr, tr, ie;
  int          sc = 0;
  int          fc = 0;
  // dut keeps the default crystal slow source
  localparam logic        SLOW_RC_EXP = 1'b0;
  localparam logic [15:0] CT = DOCVC_CTRL_OFF;
  localparam logic [15:0] ST = DOCVC_STAT_OFF;

  docvc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .slow_osc_i(s_osc), .fast_osc_i(f_osc), .sleep_i(sleep), .core_voltage_select_o(vsel),
    .fast_osc_enable_o(osc_o), .cpu_clock_select_o(sel_o), .cpu_clk_o(cpu_clk),
    .periph_clk_o(per_clk), .timer_clk_o(tim_clk), .instr_cycle_en_o(ie_o));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // slow pin period 20 clocks, fast pin period 6 clocks: both well below the sampling limit
  always @(posedge clk_i) begin
    sc <= (sc == 9) ? 0 : sc + 1;
    fc <= (fc == 2) ? 0 : fc + 1;
    if (sc == 9) s_osc <= ~s_osc;
    if (fc == 2) f_osc <= ~f_osc;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s: got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // one classic cycle; held until ack is sampled high, released right after
  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    // no limit of its own: a missing acknowledge is ended by the watchdog
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  task automatic wr(input logic [31:0] d);
    wb(1'b1, CT, d, 4'h1);
  endtask : wr

  task automatic rdc(input logic [15:0] a, input logic [31:0] e, input string m);
    wb(1'b0, a, 32'h0, 4'h1);
    chk(q, e, m);
  endtask : rdc

  task automatic poll(input logic e);
    int n;
    n = 0;
    do begin
      wb(1'b0, ST, 32'h0, 4'h1);
      n++;
    end while (q[DOCVC_ST_MUXF] !== e && n < 40);
    chk({31'h0, q[DOCVC_ST_MUXF]}, {31'h0, e}, "mux source");
  endtask : poll

  // counts rising edges of the clock outputs and instruction pulses over a window
  task automatic watch(input int n);
    logic pc, pp, pt;
    cr = 0;
    pr = 0;
    tr = 0;
    ie = 0;
    pc = cpu_clk;
    pp = per_clk;
    pt = tim_clk;
    repeat (n) begin
      @(posedge clk_i);
      #1;
      cr += int'(cpu_clk && !pc);
      pr += int'(per_clk && !pp);
      tr += int'(tim_clk && !pt);
      ie += int'(ie_o === 1'b1);
      pc = cpu_clk;
      pp = per_clk;
      pt = tim_clk;
    end
  endtask : watch

  function automatic logic [31:0] inr(input int x, input int lo, input int hi);
    return {31'h0, x >= lo && x <= hi};
  endfunction : inr

  initial begin
    #(25 * 30000);
    error_cnt++;
    summarize();
  end

  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 16'h0;
    dat = 32'h0;
    sel = 4'h0;
    sleep = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(CT, 32'h0, "ctrl reset");
    rdc(ST, {28'h0, SLOW_RC_EXP, 3'h0}, "status reset");
    chk({28'h0, vsel, osc_o, sel_o}, 32'h0, "reset pins");
    watch(200);
    chk(inr(cr, 9, 11), 32'h1, "slow cpu clock");
    chk(inr(pr, 9, 11), 32'h1, "slow periph clock");
    chk(inr(2 * ie - cr, -2, 2), 32'h1, "instr per two");
    chk(tr, 0, "timer idle");
    $display("test reset done");
    wr(32'h8);
    rdc(CT, 32'h0, "sel blocked");
    wr(32'h3);
    wr(32'hb);
    rdc(CT, 32'h3, "sel blocked osc off");
    for (int v = 0; v < 4; v++) begin
      wr(v);
      rdc(CT, v, "voltage rw");
      chk({30'h0, vsel}, v, "voltage pin");
    end
    // code 3 suits any fast source; the settle waits are skipped since nothing here times them
    wr(32'h7);
    rdc(CT, 32'h7, "osc enable rw");
    chk({31'h0, osc_o}, 32'h1, "osc pin");
    wr(32'hf);
    rdc(CT, 32'hf, "sel rw");
    chk({31'h0, sel_o}, 32'h1, "sel pin");
    poll(1'b1);
    rdc(ST, 32'h7, "status fast");
    watch(120);
    chk(inr(cr, 18, 22), 32'h1, "fast cpu clock");
    chk(inr(tr, 18, 22), 32'h1, "timer clock");
    chk(inr(2 * ie - cr, -2, 2), 32'h1, "instr fast");
    $display("test fast switch done");
    wr(32'hc);
    rdc(CT, 32'hc, "stored sel kept");
    chk({31'h0, sel_o}, 32'h0, "hw disable");
    poll(1'b0);
    wr(32'hf);
    rdc(CT, 32'h7, "sel gated at zero code");
    wr(32'hf);
    wr(32'h7);
    chk({31'h0, sel_o}, 32'h0, "deselect");
    poll(1'b0);
    wr(32'h3);
    chk({31'h0, osc_o}, 32'h0, "osc off");
    wr(32'h0);
    wr(32'h3);
    wr(32'hf);
    rdc(CT, 32'h7, "one write no select");
    $display("test return done");
    @(posedge clk_i);
    sleep <= 1'b1;
    @(posedge clk_i);
    #1;
    chk({31'h0, osc_o}, 32'h0, "sleep stops fast");
    watch(100);
    chk(pr + tr, 0, "sleep gates clocks");
    rdc(ST, 32'h0, "status sleep");
    @(posedge clk_i);
    sleep <= 1'b0;
    watch(100);
    chk(inr(pr, 4, 6), 32'h1, "wake periph");
    $display("test sleep done");
    wb(1'b1, 16'hff08, 32'hf, 4'h1);
    rdc(16'hff08, 32'h0, "unmapped read");
    wb(1'b1, CT, 32'h0, 4'h0);
    wb(1'b1, ST, 32'hf, 4'h1);
    rdc(CT, 32'h7, "ignored writes");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(CT, 32'h0, "second reset");
    $display("test refusals done");
    summarize();
  end

endmodule : docvc_top_tb_top
`default_nettype wire
